// >>> sar_pkg.sv
// Constants, types and helpers shared by the converter control logic.
// Assumes a single 10 MHz core clock and a classic Wishbone register port.
// Notes on behaviour
// - A rising convert strobe edge starts a conversion.
// - The device alternates acquisition tracking with a held conversion phase.
// - Conversion resolves 18 bits, half scale down to 1/262144, MSB first.
// - Finished bits form the 18-bit code handed to the serial output.
// - Three input ranges exist: full differential, unipolar and bipolar.
// - Range is held independently of the channel selection.
// - Channels of the current configuration drive the selector output pair.
// - A sequencer holds one to 16 host programmed configuration words.
// - Digital gain compression is switchable per configuration word.
// - Straight binary equals two's complement with the MSB inverted.
// - Full differential range outputs binary or two's complement as configured.
// - Unipolar range always outputs straight binary.
// - Bipolar range always outputs two's complement.
// - Discharge the summing node every conversion and on first new configuration.
// - The device naps by itself between conversions.
// - A sleep state below nap power serves long idle periods.
// - Busy rises at conversion start and falls when it finishes.
// - Reset during conversion aborts it and floats the serial output.
// - With read enable low, result then configuration shift out MSB first.
// - With read enable high, the output floats and the serial clock is ignored.
package sar_pkg;
  localparam int RES_BITS = 18;
  localparam int CFG_BITS = 8;
  localparam int SEQ_DEPTH = 16;
  localparam int SER_BITS = RES_BITS + CFG_BITS;
  // Configuration word fields.
  localparam int CFG_CHAN_LSB = 0;
  localparam int CFG_FMT_BIT = 4;
  localparam int CFG_RANGE_LSB = 5;
  localparam int CFG_GAIN_BIT = 7;
  localparam logic [1:0] RANGE_FULL = 2'h0;
  localparam logic [1:0] RANGE_UNI = 2'h1;
  localparam logic [1:0] RANGE_BIP = 2'h2;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_CFG_USED = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [1:0] SEQ_REGION = 2'h1;
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_DEPTH_LSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // Timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int DISCH_TIME_NS = 200;
  localparam int BIT_TIME_NS = 300;
  localparam logic [3:0] DISCH_CYCLES = 4'((DISCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] BIT_CYCLES = 4'((BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] MSB_INDEX = 5'(RES_BITS - 1);
  typedef enum logic [3:0] {
    ST_SLEEP = 4'h1,
    ST_NAP = 4'h2,
    ST_CONV = 4'h4,
    ST_DONE = 4'h8
  } sar_state_t;

  // Turns the raw straight binary code into the format the range demands.
  function automatic logic [RES_BITS-1:0] sar_format(input logic [RES_BITS-1:0] raw, input logic [CFG_BITS-1:0] cfg);
    logic twos;
    twos = 1'b0;
    unique case (cfg[CFG_RANGE_LSB +: 2])
      RANGE_UNI: twos = 1'b0;
      RANGE_BIP: twos = 1'b1;
      default: twos = cfg[CFG_FMT_BIT];
    endcase
    sar_format = twos ? {~raw[RES_BITS-1], raw[RES_BITS-2:0]} : raw;
  endfunction : sar_format
endpackage : sar_pkg

// >>> sar_ser_if.sv
// Link between the conversion core and the serial output shifter.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
`default_nettype none
interface sar_ser_if;
  import sar_pkg::*;
  logic [SER_BITS-1:0] word;
  logic abort;
  modport ctrl (output word, output abort);
  modport ser (input word, input abort);
endinterface : sar_ser_if
`default_nettype wire

// >>> sar_serial_out.sv
// Serial result shifter driven by the host shift clock and read enable.
// Assumes the shift clock is far slower than the core clock and is sampled.
`timescale 1ns/10ps
`default_nettype none
module sar_serial_out
  import sar_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic read_enable_low_n_i,
  sar_ser_if.ser ser,
  output logic sdo_o,
  output logic sdo_oe_o
);
  logic [2:0] sck_sync_r;
  logic [1:0] rdl_sync_r;
  logic sck_rise;
  logic enabled;
  logic blocked_r;
  logic oe_r;
  logic [SER_BITS-1:0] shift_r;

  // Two-stage synchronisers; the third shift clock stage only finds edges.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_sync_r <= 3'h0;
      rdl_sync_r <= 2'h3;
    end else begin
      sck_sync_r <= {sck_sync_r[1:0], sck_i};
      rdl_sync_r <= {rdl_sync_r[0], read_enable_low_n_i};
    end
  end

  assign sck_rise = sck_sync_r[1] & ~sck_sync_r[2];
  assign enabled = ~rdl_sync_r[1];

  // While reads are disabled the word is reloaded, so each read starts at its MSB.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_r <= '0;
    end else if (!enabled) begin
      shift_r <= ser.word;
    end else if (sck_rise) begin
      shift_r <= {shift_r[SER_BITS-2:0], 1'b0};
    end
  end

  // An abort floats the output until the host ends the read.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blocked_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      if (ser.abort) begin
        blocked_r <= 1'b1;
      end else if (!enabled) begin
        blocked_r <= 1'b0;
      end
      oe_r <= enabled & ~blocked_r & ~ser.abort;
    end
  end

  assign sdo_o = shift_r[SER_BITS-1];
  assign sdo_oe_o = oe_r;
endmodule : sar_serial_out
`default_nettype wire

// >>> sar_conv_ctrl.sv
// Top of the converter control: bit sequencing, sequencer, power states, registers.
// Assumes a Wishbone classic master on the core clock and asynchronous pins.
`timescale 1ns/10ps
`default_nettype none
module sar_conv_ctrl
  import sar_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic convert_strobe_i,
  input wire logic device_reset_i,
  input wire logic comparator_i,
  input wire logic sck_i,
  input wire logic read_enable_low_n_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  output logic busy_o,
  output logic acquire_o,
  output logic nap_o,
  output logic sleep_o,
  output logic discharge_o,
  output logic [RES_BITS-1:0] dac_code_o,
  output logic [3:0] mux_select_o,
  output logic [1:0] range_o,
  output logic gain_compression_o
);
  sar_ser_if ser_link ();

  logic [2:0] cnv_sync_r;
  logic [1:0] devrst_sync_r;
  logic [1:0] comp_sync_r;
  logic cnv_rise;
  logic dev_reset;
  logic comp_keep;

  sar_state_t state_r;
  sar_state_t state_nxt;
  logic conv_start;
  logic bit_done;
  logic last_bit;

  logic [4:0] bit_r;
  logic [3:0] phase_r;
  logic [RES_BITS-1:0] sar_r;

  logic [7:0] ctrl_r;
  logic [CFG_BITS-1:0] seq_mem_r [SEQ_DEPTH];
  logic [3:0] cfg_idx_r;
  logic [CFG_BITS-1:0] active_cfg_r;
  logic [3:0] depth_m1;
  logic sleep_req;

  logic [RES_BITS-1:0] result_r;
  logic [CFG_BITS-1:0] result_cfg_r;
  logic [15:0] conv_count_r;

  logic [3:0] disch_cnt_r;
  logic discharge_r;
  logic disch_start;

  logic busy_r;
  logic acquire_r;
  logic nap_r;
  logic sleep_r;
  logic abort_r;

  logic bus_req;
  logic bus_wr;
  logic ack_r;
  logic [31:0] dat_r;
  logic seq0_write;

  // True when the address falls in the sequencer word window.
  function automatic logic in_seq(input logic [7:0] adr);
    in_seq = (adr[7:6] == SEQ_REGION);
  endfunction : in_seq

  // Pin inputs pass two flip-flops; the convert strobe keeps a third for edges.
  // A strobe held high yields a single edge, so one pulse starts at most one conversion.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnv_sync_r <= 3'h0;
      devrst_sync_r <= 2'h0;
      comp_sync_r <= 2'h0;
    end else begin
      cnv_sync_r <= {cnv_sync_r[1:0], convert_strobe_i};
      devrst_sync_r <= {devrst_sync_r[0], device_reset_i};
      comp_sync_r <= {comp_sync_r[0], comparator_i};
    end
  end

  assign cnv_rise = cnv_sync_r[1] & ~cnv_sync_r[2];
  assign dev_reset = devrst_sync_r[1];
  assign comp_keep = comp_sync_r[1];

  // Control fields decoded from the control register.
  assign sleep_req = ctrl_r[CTRL_SLEEP_BIT];
  assign depth_m1 = ctrl_r[CTRL_DEPTH_LSB +: 4];

  // Bit timing: each decision waits for the synchronised comparator answer.
  // The answer is read on the third cycle of a bit, two synchroniser stages after the trial moved.
  assign bit_done = (phase_r == BIT_CYCLES - 4'h1);
  assign last_bit = (bit_r == 5'h00);
  assign conv_start = (state_r == ST_NAP) && (state_nxt == ST_CONV);

  // Power and phase sequencing; nap is the resting state between conversions.
  // Strobe edges outside nap are dropped, so a running conversion can never restart half way.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_SLEEP: begin
        if (!sleep_req) begin
          state_nxt = ST_NAP;
        end
      end
      ST_NAP: begin
        if (dev_reset) begin
          state_nxt = ST_NAP;
        end else if (sleep_req) begin
          state_nxt = ST_SLEEP;
        end else if (cnv_rise) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (dev_reset) begin
          state_nxt = ST_NAP;
        end else if (bit_done && last_bit) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_NAP;
      end
      default: begin
        state_nxt = ST_NAP;
      end
    endcase
  end

  // State register.
  // Reset lands in nap, the lowest state from which a strobe is still accepted.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_NAP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Successive approximation: set a trial bit, then keep or drop it on the comparator.
  // The code left in the trial register after the last bit is the straight binary result.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_r <= 5'h00;
      phase_r <= 4'h0;
      sar_r <= '0;
    end else if (conv_start) begin
      bit_r <= MSB_INDEX;
      phase_r <= 4'h0;
      sar_r <= {1'b1, {(RES_BITS-1){1'b0}}};
    end else if (state_r == ST_CONV) begin
      if (bit_done) begin
        phase_r <= 4'h0;
        if (!comp_keep) begin
          sar_r[bit_r] <= 1'b0;
        end
        if (!last_bit) begin
          sar_r[bit_r - 5'h01] <= 1'b1;
          bit_r <= bit_r - 5'h01;
        end
      end else begin
        phase_r <= phase_r + 4'h1;
      end
    end
  end

  // Configuration that drives the selector: follows the sequencer while tracking, frozen in conversion.
  // It stays frozen through the done cycle, so the format and the reported word match the sample.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_cfg_r <= CFG_RESET;
    end else if ((state_nxt == ST_NAP) || (state_nxt == ST_SLEEP)) begin
      active_cfg_r <= seq_mem_r[cfg_idx_r];
    end
  end

  // Sequencer index advances after each result and wraps after the last programmed word.
  // Shrinking the depth below the current index wraps at the next result rather than running on to the end.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_idx_r <= 4'h0;
    end else if (dev_reset) begin
      cfg_idx_r <= 4'h0;
    end else if (state_r == ST_DONE) begin
      if (cfg_idx_r >= depth_m1) begin
        cfg_idx_r <= 4'h0;
      end else begin
        cfg_idx_r <= cfg_idx_r + 4'h1;
      end
    end
  end

  // Result capture; it stays put until the next conversion completes.
  // Reads in between always see a complete code, never a partial trial.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_r <= '0;
      result_cfg_r <= CFG_RESET;
      conv_count_r <= 16'h0000;
    end else if (state_r == ST_DONE) begin
      result_r <= sar_format(sar_r, active_cfg_r);
      result_cfg_r <= active_cfg_r;
      conv_count_r <= conv_count_r + 16'h0001;
    end
  end

  // The summing node is discharged at each conversion and when word zero is rewritten.
  // A second trigger while the switch is closed simply restarts the count.
  assign disch_start = conv_start | seq0_write;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      disch_cnt_r <= 4'h0;
      discharge_r <= 1'b0;
    end else if (disch_start) begin
      disch_cnt_r <= DISCH_CYCLES;
      discharge_r <= 1'b1;
    end else if (disch_cnt_r != 4'h0) begin
      disch_cnt_r <= disch_cnt_r - 4'h1;
      discharge_r <= (disch_cnt_r != 4'h1);
    end
  end

  // Status pins follow the next state so they line up with the phase change.
  // The abort request is registered too, so the shifter sees it one cycle after the synchronised reset.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_r <= 1'b0;
      acquire_r <= 1'b1;
      nap_r <= 1'b1;
      sleep_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt == ST_CONV);
      acquire_r <= (state_nxt == ST_NAP) || (state_nxt == ST_DONE);
      nap_r <= (state_nxt == ST_NAP);
      sleep_r <= (state_nxt == ST_SLEEP);
      abort_r <= dev_reset;
    end
  end

  // Wishbone classic slave: one wait state, ack drops the cycle after it rises.
  // A request is taken only while ack is low, so a strobe still high in the ack cycle cannot store a write twice.
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign seq0_write = bus_wr && in_seq(wb_adr_i) && (wb_adr_i[5:2] == 4'h0);

  // Control register write; byte lane zero holds every control field.
  // A write without byte lane zero enabled leaves every field unchanged.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CTRL_RESET;
    end else if (bus_wr && (wb_adr_i == ADDR_CTRL)) begin
      ctrl_r <= wb_dat_i[7:0];
    end
  end

  // Sequencer storage: range, format, gain and channel held as separate fields.
  // Any word may be rewritten between conversions; the running one is held in the active copy.
  generate
    for (genvar i = 0; i < SEQ_DEPTH; i++) begin : g_seq
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          seq_mem_r[i] <= CFG_RESET;
        end else if (bus_wr && in_seq(wb_adr_i) && (wb_adr_i[5:2] == 4'(i))) begin
          seq_mem_r[i] <= wb_dat_i[CFG_BITS-1:0];
        end
      end
    end
  endgenerate

  // Read data and acknowledge; unmapped addresses read as zero and are acknowledged.
  // Reads have no side effects, so software may poll any register freely.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= bus_req;
      if (bus_req && !wb_we_i) begin
        if (in_seq(wb_adr_i)) begin
          dat_r <= {24'h000000, seq_mem_r[wb_adr_i[5:2]]};
        end else begin
          unique case (wb_adr_i)
            ADDR_CTRL: dat_r <= {24'h000000, ctrl_r};
            ADDR_STATUS: dat_r <= {19'h00000, sleep_req, cfg_idx_r, 3'h0, state_r, busy_r};
            ADDR_RESULT: dat_r <= {14'h0000, result_r};
            ADDR_CFG_USED: dat_r <= {24'h000000, result_cfg_r};
            ADDR_COUNT: dat_r <= {16'h0000, conv_count_r};
            default: dat_r <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // Word handed to the shifter: result first, then the configuration it used.
  // The shifter reloads it whenever reads are disabled, so a read shows the latest pair.
  assign ser_link.word = {result_r, result_cfg_r};
  assign ser_link.abort = abort_r;

  sar_serial_out u_serial (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .sck_i(sck_i),
    .read_enable_low_n_i(read_enable_low_n_i),
    .ser(ser_link.ser),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o)
  );

  // Register driven outputs.
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign busy_o = busy_r;
  assign acquire_o = acquire_r;
  assign nap_o = nap_r;
  assign sleep_o = sleep_r;
  assign discharge_o = discharge_r;
  assign dac_code_o = sar_r;
  // Range and channel come from independent fields of the same word.
  assign mux_select_o = active_cfg_r[CFG_CHAN_LSB +: 4];
  assign range_o = active_cfg_r[CFG_RANGE_LSB +: 2];
  assign gain_compression_o = active_cfg_r[CFG_GAIN_BIT];
endmodule : sar_conv_ctrl
`default_nettype wire

// >>> sar_conv_asserts.sv
// Checker bound to the converter control top: conversion timing and pin relations.
// Assumes one core clock domain and the top's port names.
`timescale 1ns/10ps
`default_nettype none
module sar_conv_asserts
  import sar_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic device_reset_i,
  input wire logic read_enable_low_n_i,
  input wire logic sdo_oe_o,
  input wire logic busy_o,
  input wire logic acquire_o,
  input wire logic nap_o,
  input wire logic sleep_o,
  input wire logic discharge_o,
  input wire logic [RES_BITS-1:0] dac_code_o,
  input wire logic [3:0] mux_select_o,
  input wire logic [1:0] range_o
);
  logic [7:0] busy_cnt_r;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Counts the cycles of the running conversion.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt_r <= 8'h00;
    end else begin
      busy_cnt_r <= busy_o ? busy_cnt_r + 8'h01 : 8'h00;
    end
  end
  a_conv_length: assert property ($fell(busy_o) && !device_reset_i |-> busy_cnt_r == 8'h36)
    else $error("conversion length wrong");
  a_trial_start: assert property ($rose(busy_o) |-> ##[0:1] dac_code_o == 18'h20000)
    else $error("first trial not half scale");
  a_disch_conv: assert property ($rose(busy_o) |-> ##[0:1] discharge_o)
    else $error("no discharge at conversion start");
  a_busy_phase: assert property (busy_o |-> !nap_o && !acquire_o && !sleep_o)
    else $error("busy overlaps nap or tracking");
  a_nap_return: assert property ($fell(busy_o) && !device_reset_i |-> ##[0:2] nap_o && acquire_o)
    else $error("no nap after conversion");
  a_cfg_frozen: assert property (busy_o && $past(busy_o) |-> $stable(mux_select_o) && $stable(range_o))
    else $error("channel or range moved in conversion");
  a_sleep_idle: assert property (sleep_o |-> !busy_o && !nap_o)
    else $error("sleep overlaps activity");
  a_out_float: assert property (read_enable_low_n_i [*5] |-> !sdo_oe_o)
    else $error("serial output driven while disabled");
  a_reset_float: assert property (device_reset_i [*5] |-> !sdo_oe_o && !busy_o)
    else $error("device reset left output or busy");
  c_conv: cover property ($rose(busy_o));
  c_cfg_disch: cover property (discharge_o && !busy_o);
  c_read: cover property ($rose(sdo_oe_o));
endmodule : sar_conv_asserts
`default_nettype wire

// >>> sar_host_model.sv
// Host side model: comparator on the held level and the serial read frame.
// Assumes the core clock paces frame starts; the shift clock runs only in frames.
`timescale 1ns/10ps
`default_nettype none
module sar_host_model
  import sar_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic start_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  input wire logic [RES_BITS-1:0] dac_code_i,
  input wire logic [RES_BITS-1:0] level_i,
  output logic comparator_o,
  output logic sck_o,
  output logic read_enable_low_n_o,
  output logic [SER_BITS-1:0] word_o,
  output logic oe_seen_o,
  output logic done_o
);
  logic line_last;
  // The comparator keeps a trial bit while the level reaches the trial code.
  assign comparator_o = level_i >= dac_code_i;
  // A frame lowers read enable, takes each bit just before its shift edge, then releases.
  initial begin
    {sck_o, word_o, oe_seen_o, done_o, line_last} = '0;
    read_enable_low_n_o = 1'b1;
    forever begin
      @(posedge core_clk_i);
      if (start_i === 1'b1) begin
        done_o = 1'b0;
        oe_seen_o = 1'b1;
        read_enable_low_n_o <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        #37;
        for (int i = SER_BITS - 1; i >= 0; i--) begin
          line_last = sdo_oe_i ? sdo_i : ~line_last;
          word_o[i] = line_last;
          oe_seen_o = oe_seen_o & sdo_oe_i;
          sck_o = 1'b1;
          #400;
          sck_o = 1'b0;
          #400;
        end
        read_enable_low_n_o = 1'b1;
        done_o = 1'b1;
      end
    end
  end
endmodule : sar_host_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench: register bus, sequenced conversions, serial reads, sleep, abort.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sar_pkg::*;
  logic clk, rst_n, cyc, stb, we, ack, conv, drst, cmp, sck, rdl_n, sdo, oe;
  logic busy, acq, nap, slp, dis, gc, rd_go, rd_done, oe_all;
  logic [7:0] adr;
  logic [31:0] wdat, rdat;
  logic [17:0] dac, lvl;
  logic [3:0] mux;
  logic [1:0] rng;
  logic [25:0] word;
  logic [15:0] lfsr;
  logic [7:0] seq [4];
  logic [25:0] exp_q [$];
  int error_cnt, compares, cyc_cnt, dis_cnt, count, idx, mark;
  sar_conv_ctrl uut (.core_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .convert_strobe_i(conv), .device_reset_i(drst), .comparator_i(cmp), .sck_i(sck),
    .read_enable_low_n_i(rdl_n), .sdo_o(sdo), .sdo_oe_o(oe), .busy_o(busy), .acquire_o(acq), .nap_o(nap),
    .sleep_o(slp), .discharge_o(dis), .dac_code_o(dac), .mux_select_o(mux), .range_o(rng),
    .gain_compression_o(gc));
  sar_host_model host (.core_clk_i(clk), .start_i(rd_go), .sdo_i(sdo), .sdo_oe_i(oe), .dac_code_i(dac),
    .level_i(lvl), .comparator_o(cmp), .sck_o(sck), .read_enable_low_n_o(rdl_n), .word_o(word),
    .oe_seen_o(oe_all), .done_o(rd_done));
  // Clock, discharge cycle count and the run limit.
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc_cnt++;
    dis_cnt = dis_cnt + (dis === 1'b1);
    if (cyc_cnt > 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic test_done();
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step
  // One classic cycle: hold the request until ack is seen, then release for a cycle.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    q = rdat;
    check("wb_ack", {ack, 31'(n)}, {1'b1, 31'h2});
    {cyc, stb, we} <= 3'h0;
    @(posedge clk);
  endtask : wb
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask : rdchk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask : wait_lvl
  task automatic serial_read();
    rd_go <= 1'b1;
    @(posedge clk);
    rd_go <= 1'b0;
    @(posedge clk);
    wait_lvl(rd_done, 1'b1, 300);
  endtask : serial_read
  // One conversion with a refused strobe inside it, then result, status and serial checks.
  task automatic convert(input logic [17:0] l, input logic [7:0] c);
    logic [17:0] e;
    e = (c[6:5] == 2'h2 || (c[6:5] != 2'h1 && c[4])) ? l ^ 18'h20000 : l;
    mark = dis_cnt;
    lvl <= l;
    conv <= 1'b1;
    wait_lvl(busy, 1'b1, 20);
    check("busy_rise", {31'h0, busy}, 32'h1);
    conv <= 1'b0;
    repeat (4) @(posedge clk);
    conv <= 1'b1;
    @(negedge clk);
    check("chan", {25'h0, gc, rng, mux}, {25'h0, c[7:5], c[3:0]});
    wait_lvl(busy, 1'b0, 80);
    conv <= 1'b0;
    count++;
    idx = (idx + 1) % 4;
    repeat (3) @(posedge clk);
    check("dischg", dis_cnt - mark, 32'h2);
    check("nap", {30'h0, acq, nap}, 32'h3);
    rdchk("result", ADDR_RESULT, {14'h0, e});
    rdchk("cfg_used", ADDR_CFG_USED, {24'h0, c});
    rdchk("count", ADDR_COUNT, count);
    rdchk("status", ADDR_STATUS, {20'h0, 4'(idx), 8'h04});
    exp_q.push_back({e, c});
    serial_read();
    check("serial", {6'h0, word}, {6'h0, exp_q.pop_front()});
    check("oe_on", {31'h0, oe_all}, 32'h1);
    rdchk("held", ADDR_RESULT, {14'h0, e});
    check("oe_off", {31'h0, oe}, 32'h0);
  endtask : convert
  // Main sequence.
  initial begin
    {clk, rst_n, cyc, stb, we, conv, drst, rd_go, adr, wdat, lvl} = '0;
    {error_cnt, compares, cyc_cnt, dis_cnt, count, idx} = '0;
    lfsr = 16'hBDE7;
    seq = '{8'h01, 8'h93, 8'hB5, 8'h47};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk("ctrl_rst", ADDR_CTRL, 32'h0);
    rdchk("status_rst", ADDR_STATUS, 32'h4);
    rdchk("seq_rst", 8'h4C, 32'h0);
    rdchk("unmapped", 8'h30, 32'h0);
    mark = dis_cnt;
    for (int i = 0; i < 4; i++) wr(8'h40 + 8'(4 * i), {24'h0, seq[i]});
    check("cfg_dischg", dis_cnt - mark, 32'h2);
    for (int i = 0; i < 4; i++) rdchk("seq_rd", 8'h40 + 8'(4 * i), {24'h0, seq[i]});
    wr(ADDR_CTRL, 32'h30);
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_step(lfsr);
      convert(i == 0 ? 18'h3FFFF : i == 1 ? 18'h00000 : {lfsr, lfsr[1:0]}, seq[idx]);
    end
    wr(ADDR_CTRL, 32'h31);
    conv <= 1'b1;
    repeat (70) @(posedge clk);
    check("sleep", {30'h0, slp, nap}, 32'h2);
    conv <= 1'b0;
    rdchk("sleep_cnt", ADDR_COUNT, count);
    wr(ADDR_CTRL, 32'h30);
    repeat (3) @(posedge clk);
    check("wake", {30'h0, slp, nap}, 32'h1);
    conv <= 1'b1;
    wait_lvl(busy, 1'b1, 20);
    conv <= 1'b0;
    repeat (10) @(posedge clk);
    drst <= 1'b1;
    repeat (6) @(posedge clk);
    check("abort", {31'h0, busy}, 32'h0);
    serial_read();
    check("float", {31'h0, oe_all}, 32'h0);
    drst <= 1'b0;
    repeat (5) @(posedge clk);
    idx = 0;
    rdchk("abort_cnt", ADDR_COUNT, count);
    convert({lfsr, 2'h3}, seq[0]);
    test_done();
  end
endmodule : tb_top
bind sar_conv_ctrl sar_conv_asserts u_chk (.core_clk_i, .rst_n_i, .device_reset_i, .read_enable_low_n_i,
  .sdo_oe_o, .busy_o, .acquire_o, .nap_o, .sleep_o, .discharge_o, .dac_code_o, .mux_select_o, .range_o);
`default_nettype wire
